// ==== hw/ccru_consts.vh ====
// constants for the configuration loader with chain and remote update
// Notes on behaviour
// - flash reads default async; writes always async
// - master makes config_clock, times whole load
// - own data loaded then chain out low
// - last chain out unused or user pin
// - request, status, complete, clock, data shared
// - first device master, others fast passive slaves
// - byte-wide and word-wide data bus both supported
// - passive serial: bit per clock on data0
// - cable: user start-up clock option ignored
// - user clock may source config_clock, 40 MHz max
// - select becomes flash enable; data out becomes data1
// - remote mode: factory first, it picks application
// - application image starts at any sector boundary
// - user watchdog catches application functional errors
// - serial scheme factory boot address zero
// - factory image is fall-back, never remotely changed
// - parallel factory address default, command changes it
`ifndef CCRU_CONSTS_VH
`define CCRU_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CCRU_OFS_CTRL 12'h000
`define CCRU_OFS_STATUS 12'h004
`define CCRU_OFS_IMAGE_LEN 12'h008
`define CCRU_OFS_FACTORY_ADDR 12'h00C
`define CCRU_OFS_APP_ADDR 12'h010
`define CCRU_OFS_WD_TIMEOUT 12'h014
`define CCRU_OFS_FLASH_WADDR 12'h018
`define CCRU_OFS_FLASH_WDATA 12'h01C
`define CCRU_OFS_RX_WORD 12'h020

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CCRU_CTRL_RECONFIG 0
`define CCRU_CTRL_AUTO_RESTART 1
`define CCRU_CTRL_WORD_WIDE 2
`define CCRU_CTRL_SYNC_READ 3
`define CCRU_CTRL_USE_USR_CLK 4
`define CCRU_CTRL_USER_IO_EN 5
`define CCRU_CTRL_USER_IO_VAL 6
`define CCRU_CTRL_WD_ENABLE 7
`define CCRU_CTRL_WD_KICK 8
`define CCRU_CTRL_RESET 9'h002

// ----------------------------------------------------------------
// reset values and layout
// ----------------------------------------------------------------
`define CCRU_AS_BOOT_ADDR 24'h000000
`define CCRU_AP_BOOT_ADDR 24'h010000
`define CCRU_SECTOR_BITS 16
`define CCRU_IMAGE_LEN_RESET 32'h00000010
`define CCRU_WD_TIMEOUT_RESET 32'h00001000

// ----------------------------------------------------------------
// scheme select encodings
// ----------------------------------------------------------------
`define CCRU_SCH_AS 2'h0
`define CCRU_SCH_AP 2'h1
`define CCRU_SCH_FPP 2'h2
`define CCRU_SCH_PS 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CCRU_CLK_NS 100
`define CCRU_USR_CLK_MAX_MHZ 40
`define CCRU_CCLK_HALF_NS 200
`define CCRU_CCLK_HALF_CYC (`CCRU_CCLK_HALF_NS / `CCRU_CLK_NS)
`define CCRU_WE_MIN_NS 70
`define CCRU_WE_CYC ((`CCRU_WE_MIN_NS + `CCRU_CLK_NS - 1) / `CCRU_CLK_NS)

`endif

// ==== hw/ccru_clkdiv.v ====
// configuration clock generator, internal divider or user start-up clock
`timescale 1ns/10ps
`include "ccru_consts.vh"
module ccru_clkdiv (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // control
  input wire run_i,
  input wire use_usr_i,
  input wire usr_clk_i,
  // generated clock
  output reg cclk_o,
  output wire rise_o
);

  reg [7:0] cnt_q;
  reg usr_q;
  wire int_rise;

  // internal divider toggles every half period
  assign int_rise = run_i && !use_usr_i && !cclk_o && (cnt_q == `CCRU_CCLK_HALF_CYC - 1);
  // user clock edges only seen as fast as clk_i samples them
  assign rise_o = use_usr_i ? (run_i && usr_clk_i && !usr_q) : int_rise;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
      cclk_o <= 1'b0;
      usr_q <= 1'b0;
    end else begin
      usr_q <= usr_clk_i;
      if (!run_i) begin
        cnt_q <= 8'h00;
        cclk_o <= 1'b0;
      end else if (use_usr_i) begin
        cclk_o <= usr_clk_i;
      end else if (cnt_q == `CCRU_CCLK_HALF_CYC - 1) begin
        cnt_q <= 8'h00;
        cclk_o <= !cclk_o;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

endmodule

// ==== hw/ccru_wdog.v ====
// user watchdog for a running application image
`timescale 1ns/10ps
module ccru_wdog (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // control
  input wire enable_i,
  input wire kick_i,
  input wire [31:0] timeout_i,
  // expiry
  output reg expire_o
);

  reg [31:0] cnt_q;

  // counts up while armed; a kick restarts the count
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 32'h00000000;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (!enable_i || kick_i) begin
        cnt_q <= 32'h00000000;
      end else if (cnt_q >= timeout_i) begin
        cnt_q <= 32'h00000000;
        expire_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h00000001;
      end
    end
  end

endmodule

// ==== hw/ccru_top.v ====
// configuration loader: chain master or slave, flash access, remote update
`timescale 1ns/10ps
`include "ccru_consts.vh"
module ccru_top (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // straps and mode inputs
  input wire [1:0] scheme_select_i,
  input wire remote_update_i,
  input wire cable_mode_i,
  input wire user_startup_clock_i,
  // shared configuration pins
  input wire config_request_n_i,
  input wire config_status_n_i,
  output wire config_status_n_o,
  output wire config_status_n_oe_n_o,
  input wire config_complete_i,
  output wire config_complete_o,
  output wire config_complete_oe_n_o,
  input wire config_clock_i,
  output wire config_clock_o,
  output wire config_clock_oe_n_o,
  input wire [15:0] data_i,
  // chain enables
  input wire chain_enable_n_i,
  output wire chain_enable_out_n_o,
  // flash side
  output wire serial_select_n_o,
  output wire serial_data_out_o,
  output wire serial_data_out_oe_n_o,
  output wire [23:0] flash_addr_o,
  output wire flash_oe_n_o,
  output reg flash_we_n_o,
  output reg [15:0] flash_wdata_o,
  output wire flash_data_oe_n_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam S_INIT = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_LOAD = 3'h2;
  localparam S_DONE = 3'h3;
  localparam S_ERR = 3'h4;

  reg rst_meta_q, rst_n_q;
  reg [2:0] state_q;
  reg [8:0] ctrl_q;
  reg [31:0] image_len_q, wd_timeout_q, load_cnt_q;
  reg [23:0] factory_addr_q, app_addr_q, flash_waddr_q, addr_q;
  reg [15:0] rx_word_q;
  reg [4:0] ashift_cnt_q;
  reg [23:0] ashift_q;
  reg app_run_q, loading_app_q, fallback_q, error_q, cclk_in_q, we_busy_q;
  reg [3:0] we_cnt_q;
  reg [31:0] rdata;
  reg map_hit;

  wire is_master, is_serial_master, is_ap, unit_bit, cclk_rise, wd_expire;
  wire slave_tick, load_tick, bus_wr, bus_rd, recfg, kick;
  wire [31:0] unit_cnt;

  // ----------------------------------------------------------------
  // reset release through two flops
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // scheme decode
  // ----------------------------------------------------------------
  assign is_ap = (scheme_select_i == `CCRU_SCH_AP);
  assign is_serial_master = (scheme_select_i == `CCRU_SCH_AS);
  assign is_master = is_ap || is_serial_master;
  // one bit per clock for serial schemes, else byte or word lanes
  assign unit_bit = is_serial_master || (scheme_select_i == `CCRU_SCH_PS);

  // ----------------------------------------------------------------
  // configuration clock: made here when master, sampled when slave
  // ----------------------------------------------------------------
  // cable loads never honour the user clock option
  ccru_clkdiv u_clkdiv (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .run_i(is_master && (state_q == S_ADDR || state_q == S_LOAD)),
    .use_usr_i(ctrl_q[`CCRU_CTRL_USE_USR_CLK] && !cable_mode_i),
    .usr_clk_i(user_startup_clock_i),
    .cclk_o(config_clock_o),
    .rise_o(cclk_rise)
  );

  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cclk_in_q <= 1'b0;
    end else begin
      cclk_in_q <= config_clock_i;
    end
  end

  // slave takes a unit only on a clock rise with its chain enable low
  assign slave_tick = !is_master && config_clock_i && !cclk_in_q && !chain_enable_n_i;
  assign load_tick = is_master ? cclk_rise : slave_tick;

  // ----------------------------------------------------------------
  // user watchdog, armed only while an application image runs
  // ----------------------------------------------------------------
  ccru_wdog u_wdog (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .enable_i(app_run_q && ctrl_q[`CCRU_CTRL_WD_ENABLE]),
    .kick_i(kick),
    .timeout_i(wd_timeout_q),
    .expire_o(wd_expire)
  );

  // ----------------------------------------------------------------
  // apb decode; zero wait states
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign bus_wr = psel && penable && pwrite;
  assign bus_rd = psel && penable && !pwrite;
  assign pslverr = psel && penable && !map_hit;
  assign prdata = bus_rd ? rdata : 32'h00000000;
  assign recfg = bus_wr && (paddr == `CCRU_OFS_CTRL) && pwdata[`CCRU_CTRL_RECONFIG];
  assign kick = bus_wr && (paddr == `CCRU_OFS_CTRL) && pwdata[`CCRU_CTRL_WD_KICK];

  always @* begin
    rdata = 32'h00000000;
    map_hit = 1'b1;
    if (paddr == `CCRU_OFS_CTRL) begin
      rdata = {23'h000000, ctrl_q};
    end else if (paddr == `CCRU_OFS_STATUS) begin
      rdata = {24'h000000, we_busy_q, fallback_q, error_q, app_run_q, loading_app_q, state_q};
    end else if (paddr == `CCRU_OFS_IMAGE_LEN) begin
      rdata = image_len_q;
    end else if (paddr == `CCRU_OFS_FACTORY_ADDR) begin
      rdata = {8'h00, factory_addr_q};
    end else if (paddr == `CCRU_OFS_APP_ADDR) begin
      rdata = {8'h00, app_addr_q};
    end else if (paddr == `CCRU_OFS_WD_TIMEOUT) begin
      rdata = wd_timeout_q;
    end else if (paddr == `CCRU_OFS_FLASH_WADDR) begin
      rdata = {8'h00, flash_waddr_q};
    end else if (paddr == `CCRU_OFS_FLASH_WDATA) begin
      rdata = {16'h0000, flash_wdata_o};
    end else if (paddr == `CCRU_OFS_RX_WORD) begin
      rdata = {16'h0000, rx_word_q};
    end else begin
      map_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // reconfig and kick bits are pulses and never stored
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `CCRU_CTRL_RESET;
      image_len_q <= `CCRU_IMAGE_LEN_RESET;
      factory_addr_q <= `CCRU_AP_BOOT_ADDR;
      app_addr_q <= 24'h000000;
      wd_timeout_q <= `CCRU_WD_TIMEOUT_RESET;
      flash_waddr_q <= 24'h000000;
    end else if (bus_wr) begin
      if (paddr == `CCRU_OFS_CTRL) begin
        ctrl_q <= {1'b0, pwdata[7:1], 1'b0};
      end else if (paddr == `CCRU_OFS_IMAGE_LEN) begin
        image_len_q <= pwdata;
      end else if (paddr == `CCRU_OFS_FACTORY_ADDR && !app_run_q && !loading_app_q) begin
        factory_addr_q <= pwdata[23:0];
      end else if (paddr == `CCRU_OFS_APP_ADDR) begin
        app_addr_q <= {pwdata[23:`CCRU_SECTOR_BITS], {`CCRU_SECTOR_BITS{1'b0}}};
      end else if (paddr == `CCRU_OFS_WD_TIMEOUT) begin
        wd_timeout_q <= pwdata;
      end else if (paddr == `CCRU_OFS_FLASH_WADDR) begin
        flash_waddr_q <= pwdata[23:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // asynchronous flash write strobe, refused during a load
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flash_we_n_o <= 1'b1;
      flash_wdata_o <= 16'h0000;
      we_busy_q <= 1'b0;
      we_cnt_q <= 4'h0;
    end else if (we_busy_q) begin
      if (we_cnt_q == `CCRU_WE_CYC) begin
        flash_we_n_o <= 1'b1;
        we_busy_q <= 1'b0;
        we_cnt_q <= 4'h0;
      end else begin
        we_cnt_q <= we_cnt_q + 4'h1;
      end
    end else if (bus_wr && paddr == `CCRU_OFS_FLASH_WDATA && state_q != S_LOAD && state_q != S_ADDR) begin
      flash_wdata_o <= pwdata[15:0];
      flash_we_n_o <= 1'b0;
      we_busy_q <= 1'b1;
      we_cnt_q <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // load sequencer
  // ----------------------------------------------------------------
  // units taken including this one; a serial unit is one bit
  assign unit_cnt = load_cnt_q + 32'h00000001;

  always @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_INIT;
      addr_q <= 24'h000000;
      load_cnt_q <= 32'h00000000;
      rx_word_q <= 16'h0000;
      ashift_q <= 24'h000000;
      ashift_cnt_q <= 5'h00;
      app_run_q <= 1'b0;
      loading_app_q <= 1'b0;
      fallback_q <= 1'b0;
      error_q <= 1'b0;
    end else if (!config_request_n_i) begin
      // request low holds everything in init and drops the app
      state_q <= S_INIT;
      app_run_q <= 1'b0;
      loading_app_q <= 1'b0;
      error_q <= 1'b0;
    end else begin
      case (state_q)
        S_INIT: begin
          load_cnt_q <= 32'h00000000;
          if (loading_app_q) begin
            addr_q <= app_addr_q;
          end else if (remote_update_i && is_ap) begin
            addr_q <= factory_addr_q;
          end else begin
            addr_q <= `CCRU_AS_BOOT_ADDR;
          end
          ashift_cnt_q <= 5'h00;
          // chain enable gates every device, master included
          if (!chain_enable_n_i && config_status_n_i) begin
            state_q <= is_serial_master ? S_ADDR : S_LOAD;
          end
        end
        S_ADDR: begin
          // serial master sends the 24-bit start address first
          if (ashift_cnt_q == 5'h00 && !cclk_rise) begin
            ashift_q <= addr_q;
          end
          if (cclk_rise) begin
            ashift_q <= {ashift_q[22:0], 1'b0};
            ashift_cnt_q <= ashift_cnt_q + 5'h01;
            if (ashift_cnt_q == 5'h17) begin
              state_q <= S_LOAD;
            end
          end
        end
        S_LOAD: begin
          if (!config_status_n_i) begin
            state_q <= S_ERR;
            error_q <= 1'b1;
          end else if (load_tick) begin
            if (unit_bit) begin
              rx_word_q <= {rx_word_q[14:0], data_i[0]};
            end else if (ctrl_q[`CCRU_CTRL_WORD_WIDE]) begin
              rx_word_q <= data_i;
            end else begin
              rx_word_q <= {rx_word_q[7:0], data_i[7:0]};
            end
            if (!unit_bit || unit_cnt[3:0] == 4'h0) begin
              addr_q <= addr_q + 24'h000001;
            end
            load_cnt_q <= unit_cnt;
            if (unit_cnt == image_len_q) begin
              state_q <= S_DONE;
              app_run_q <= loading_app_q;
            end
          end
        end
        S_DONE: begin
          if (wd_expire) begin
            // fall back to the factory image on a watchdog bite
            state_q <= S_ERR;
            error_q <= 1'b1;
            fallback_q <= 1'b1;
            app_run_q <= 1'b0;
            loading_app_q <= 1'b0;
          end else if (recfg && remote_update_i && !app_run_q) begin
            state_q <= S_INIT;
            loading_app_q <= 1'b1;
            fallback_q <= 1'b0;
          end
        end
        S_ERR: begin
          // cable loads wait for the host to pulse the request
          if (ctrl_q[`CCRU_CTRL_AUTO_RESTART] && !cable_mode_i) begin
            state_q <= S_INIT;
            loading_app_q <= 1'b0;
          end
        end
        default: begin
          state_q <= S_INIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shared open-drain pins and chain output
  // ----------------------------------------------------------------
  // status low in reset, held request or error; released so init can exit
  assign config_status_n_o = 1'b0;
  assign config_status_n_oe_n_o = !(!rst_n_q || state_q == S_ERR || (state_q == S_INIT && !config_request_n_i));
  assign config_complete_o = 1'b0;
  assign config_complete_oe_n_o = (state_q == S_DONE);
  assign config_clock_oe_n_o = !(is_master && (state_q == S_ADDR || state_q == S_LOAD));

  // chain out high until loaded, then user pin if asked
  assign chain_enable_out_n_o = (state_q != S_DONE) ? 1'b1 :
    (ctrl_q[`CCRU_CTRL_USER_IO_EN] ? ctrl_q[`CCRU_CTRL_USER_IO_VAL] : 1'b0);

  // ----------------------------------------------------------------
  // flash pins; select and data-out double up by scheme
  // ----------------------------------------------------------------
  assign serial_select_n_o = !(is_master && (state_q == S_ADDR || state_q == S_LOAD)) && !we_busy_q;
  assign serial_data_out_o = ashift_q[23];
  assign serial_data_out_oe_n_o = !(is_serial_master && state_q == S_ADDR);
  assign flash_addr_o = we_busy_q ? flash_waddr_q : addr_q;
  // async and sync reads both sampled at the clock rise
  assign flash_oe_n_o = !(is_ap && state_q == S_LOAD);
  assign flash_data_oe_n_o = !we_busy_q;

endmodule

// ==== verif/ccru_chk.sv ====
// concurrent checks on the configuration loader top ports
`timescale 1ns/10ps
`include "ccru_consts.vh"
// ------------------------------------------------
// port checker
// ------------------------------------------------
module ccru_chk (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // apb
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pslverr,
  // straps and shared pins
  input wire [1:0] scheme_select_i,
  input wire config_status_n_i,
  input wire config_status_n_oe_n_o,
  input wire config_complete_oe_n_o,
  input wire config_clock_o,
  input wire config_clock_oe_n_o,
  input wire chain_enable_n_i,
  input wire chain_enable_out_n_o,
  // flash side
  input wire serial_select_n_o,
  input wire serial_data_out_oe_n_o,
  input wire flash_oe_n_o,
  input wire flash_we_n_o,
  input wire flash_data_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // write strobe low two cycles, bus driven
  sequence s_we;
    (!flash_we_n_o && !flash_data_oe_n_o) [*2] ##1 flash_we_n_o;
  endsequence
  // master clock rises soon after driving
  sequence s_rise;
    ##[1:8] $rose(config_clock_o);
  endsequence
  property p_we;
    $fell(flash_we_n_o) |-> s_we;
  endproperty
  a_we: assert property (p_we) else $error("flash write strobe wrong");
  property p_cclk;
    $fell(config_clock_oe_n_o) |-> s_rise;
  endproperty
  a_cclk: assert property (p_cclk) else $error("master clock idle");
  property p_slave_clk;
    scheme_select_i[1] && $stable(scheme_select_i) |-> config_clock_oe_n_o;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");
  property p_flash_sel;
    !flash_oe_n_o |-> !serial_select_n_o && scheme_select_i == `CCRU_SCH_AP;
  endproperty
  a_flash_sel: assert property (p_flash_sel) else $error("flash read unselected");
  property p_sdo;
    scheme_select_i != `CCRU_SCH_AS |-> serial_data_out_oe_n_o;
  endproperty
  a_sdo: assert property (p_sdo) else $error("data1 pin driven");
  property p_done_chain;
    $rose(config_complete_oe_n_o) |-> ##[0:1] !chain_enable_out_n_o;
  endproperty
  a_done_chain: assert property (p_done_chain) else $error("chain not passed on");
  property p_undone_chain;
    $fell(config_complete_oe_n_o) |-> ##[0:1] chain_enable_out_n_o;
  endproperty
  a_undone_chain: assert property (p_undone_chain) else $error("chain left on");
  // a disabled slave must never complete
  property p_ignore;
    chain_enable_n_i && scheme_select_i[1] && !config_complete_oe_n_o |=> !config_complete_oe_n_o;
  endproperty
  a_ignore: assert property (p_ignore) else $error("disabled slave loaded");
  property p_err;
    config_status_n_oe_n_o && !config_complete_oe_n_o && !config_status_n_i |-> ##[1:4] !config_status_n_oe_n_o;
  endproperty
  a_err: assert property (p_err) else $error("status fault not held");
  property p_apb_idle;
    !(psel && penable) |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_apb_idle: assert property (p_apb_idle) else $error("apb outputs outside access");
endmodule
bind ccru_top ccru_chk u_chk (.*);

// ==== verif/ccru_far_end.sv ====
// far-side model: upstream clock and data source plus parallel flash
`timescale 1ns/10ps
// ------------------------------------------------
// far end
// ------------------------------------------------
module ccru_far_end (
  // clock
  input wire clk_i,
  // device flash port
  input wire [23:0] flash_addr_i,
  input wire flash_oe_n_i,
  // driven lines
  output reg cclk_o,
  output wire [15:0] data_o
);
  reg [15:0] word_q;
  reg drive_q;
  initial begin
    cclk_o = 1'b0;
    word_q = 16'h0000;
    drive_q = 1'b0;
  end
  // flash word from address; idle bus shows inverse
  assign data_o = !flash_oe_n_i ? flash_addr_i[15:0] ^ 16'h5A3C : drive_q ? word_q : ~word_q;
  // one unit: data set up, clock high two cycles, clock still between units
  task send(input [15:0] w, input integer slow);
    begin
      @(posedge clk_i);
      word_q <= w;
      drive_q <= 1'b1;
      repeat (2 + slow) @(posedge clk_i);
      cclk_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      cclk_o <= 1'b0;
      drive_q <= 1'b0;
    end
  endtask
endmodule

// ==== verif/ccru_tb.sv ====
// self-checking bench for the configuration loader
`timescale 1ns/10ps
`include "ccru_consts.vh"
// ------------------------------------------------
// bench top
// ------------------------------------------------
module tb;
  reg clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [1:0] scheme = `CCRU_SCH_FPP;
  reg remote = 1'b0;
  reg req_n = 1'b1;
  reg ce_n = 1'b1;
  reg ext_stat_n = 1'b1;
  reg [31:0] rd, seed, w;
  reg se;
  integer num_errors = 0;
  integer checks = 0;
  integer i, k;
  wire [31:0] prdata;
  wire pready, pslverr, stat_oe_n, done_oe_n, ck_o, ck_oe_n, far_ck, chain_n, sdo, sdo_oe_n, fl_oe_n;
  wire [23:0] fl_addr;
  wire [15:0] far_d, wdat;
  // open-drain lines; released lines take the far-end model or bench value
  wire [15:0] bus = {far_d[15:2], sdo_oe_n ? far_d[1] : sdo, far_d[0]};
  wire stat_w = stat_oe_n ? ext_stat_n : 1'b0;
  wire ck_w = ck_oe_n ? far_ck : ck_o;
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  ccru_top uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scheme_select_i(scheme), .remote_update_i(remote), .cable_mode_i(1'b0), .user_startup_clock_i(1'b0),
    .config_request_n_i(req_n), .config_status_n_i(stat_w), .config_status_n_o(),
    .config_status_n_oe_n_o(stat_oe_n), .config_complete_i(done_oe_n), .config_complete_o(),
    .config_complete_oe_n_o(done_oe_n), .config_clock_i(ck_w), .config_clock_o(ck_o),
    .config_clock_oe_n_o(ck_oe_n), .data_i(bus), .chain_enable_n_i(ce_n), .chain_enable_out_n_o(chain_n),
    .serial_select_n_o(), .serial_data_out_o(sdo), .serial_data_out_oe_n_o(sdo_oe_n), .flash_addr_o(fl_addr),
    .flash_oe_n_o(fl_oe_n), .flash_we_n_o(), .flash_wdata_o(wdat), .flash_data_oe_n_o());
  ccru_far_end fm (.clk_i(clk_i), .flash_addr_i(fl_addr), .flash_oe_n_i(fl_oe_n), .cclk_o(far_ck), .data_o(far_d));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function [15:0] pair(input [7:0] hi, input [7:0] lo);
    pair = {hi, lo};
  endfunction
  function [15:0] fl_word(input [23:0] a);
    fl_word = a[15:0] ^ 16'h5A3C;
  endfunction
  task summarize;
    begin
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // one apb transfer; never waits unbounded for pready
  task apb(input wr, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
        @(negedge clk_i);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      chk(pready, 1'b1);
      if (pready !== 1'b1)
        summarize;
      rd = prdata;
      se = pslverr;
      @(posedge clk_i);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // poll status until the masked field matches
  task wait_st(input [7:0] m, input [7:0] v);
    integer t;
    begin
      t = 0;
      do begin
        apb(1'b0, `CCRU_OFS_STATUS, 32'h0);
        t = t + 1;
      end while ((rd[7:0] & m) !== v && t < 100);
      chk(rd[7:0] & m, v);
      if ((rd[7:0] & m) !== v)
        summarize;
    end
  endtask
  // request low while straps change
  task setup(input [1:0] sch, input [31:0] ctrl, input [31:0] len);
    begin
      req_n <= 1'b0;
      scheme <= sch;
      apb(1'b1, `CCRU_OFS_CTRL, ctrl);
      apb(1'b1, `CCRU_OFS_IMAGE_LEN, len);
      req_n <= 1'b1;
    end
  endtask
  task done_rx(input [15:0] e);
    begin
      wait_st(8'h07, 8'h03);
      apb(1'b0, `CCRU_OFS_RX_WORD, 32'h0);
      chk(rd, {16'h0000, e});
      chk(chain_n, 1'b0);
    end
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    seed = 32'hD317;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    apb(1'b0, `CCRU_OFS_FACTORY_ADDR, 32'h0);
    chk(rd, {8'h00, `CCRU_AP_BOOT_ADDR});
    apb(1'b0, `CCRU_OFS_WD_TIMEOUT, 32'h0);
    chk(rd, `CCRU_WD_TIMEOUT_RESET);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({rd[30:0], se}, 32'h1);
    w = $random(seed);
    apb(1'b1, `CCRU_OFS_APP_ADDR, w);
    apb(1'b0, `CCRU_OFS_APP_ADDR, 32'h0);
    chk(rd, {8'h00, w[23:16], 16'h0000});
    // slave not enabled yet: data must be ignored
    setup(`CCRU_SCH_FPP, 32'h6, 32'h1);
    fm.send(16'h1234, 0);
    wait_st(8'h07, 8'h00);
    ce_n <= 1'b0;
    for (i = 0; i < 3; i++) begin
      w = $random(seed);
      setup(`CCRU_SCH_FPP, 32'h6, 32'h1);
      fm.send(w[15:0], i * 3);
      done_rx(w[15:0]);
    end
    w = $random(seed);
    setup(`CCRU_SCH_FPP, 32'h2, 32'h2);
    fm.send({8'h00, w[15:8]}, 0);
    fm.send({8'h00, w[7:0]}, 1);
    done_rx(pair(w[15:8], w[7:0]));
    w = $random(seed);
    setup(`CCRU_SCH_PS, 32'h2, 32'h10);
    for (k = 15; k >= 0; k--)
      fm.send({15'h0000, w[k]}, 0);
    done_rx(w[15:0]);
    // last device: chain out as user pin
    apb(1'b1, `CCRU_OFS_CTRL, 32'h62);
    apb(1'b0, `CCRU_OFS_CTRL, 32'h0);
    chk(chain_n, 1'b1);
    w = $random(seed);
    apb(1'b1, `CCRU_OFS_FLASH_WADDR, 32'h100);
    apb(1'b1, `CCRU_OFS_FLASH_WDATA, w);
    apb(1'b0, `CCRU_OFS_CTRL, 32'h0);
    chk(wdat, w[15:0]);
    // status pulled low mid-load, no auto restart
    setup(`CCRU_SCH_FPP, 32'h4, 32'h2);
    fm.send(16'hA5A5, 0);
    ext_stat_n <= 1'b0;
    wait_st(8'h27, 8'h24);
    ext_stat_n <= 1'b1;
    remote <= 1'b1;
    for (i = 0; i < 2; i++) begin
      setup(`CCRU_SCH_AP, 32'h6 | (i << 3), 32'h1);
      done_rx(fl_word(`CCRU_AP_BOOT_ADDR));
    end
    apb(1'b1, `CCRU_OFS_APP_ADDR, 32'h30000);
    apb(1'b1, `CCRU_OFS_WD_TIMEOUT, 32'd20);
    apb(1'b1, `CCRU_OFS_CTRL, 32'h87);
    wait_st(8'h10, 8'h10);
    apb(1'b1, `CCRU_OFS_FACTORY_ADDR, 32'h50000);
    wait_st(8'h40, 8'h40);
    apb(1'b0, `CCRU_OFS_FACTORY_ADDR, 32'h0);
    chk(rd, {8'h00, `CCRU_AP_BOOT_ADDR});
    summarize;
  end
endmodule
